//--- pkg/vtp_pkg.sv
`default_nettype none
package vtp_pkg;
  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [3:0] GENERAL_INTERRUPT_CONTROL_OFF = 4'h0;
  localparam logic [3:0] FUSE_STATUS_OFF               = 4'h4;
  localparam logic [3:0] VECTOR_BASE_OFF               = 4'h8;
  localparam int VECTOR_TABLE_SELECT_BIT  = 1;
  localparam int VECTOR_CHANGE_UNLOCK_BIT = 0;
  localparam logic [7:0] GIC_RESET        = 8'h00;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int          UNLOCK_WINDOW_CYCLES = 4;
  localparam logic [2:0]  UNLOCK_WINDOW_CNT    = 3'(UNLOCK_WINDOW_CYCLES);
  localparam int          POST_WRITE_CYCLES    = 1;
  localparam logic [1:0]  POST_WRITE_CNT       = 2'(POST_WRITE_CYCLES);
  // ---------------------------------------------------------------
  // Flash words
  // ---------------------------------------------------------------
  localparam int          WADDR_W       = 12;
  localparam logic [11:0] APP_START     = 12'h000;
  localparam logic [11:0] VECTOR_OFFSET = 12'h001;
  localparam logic [4:0]  VECTOR_COUNT  = 5'h12;
  localparam logic [11:0] BOOT_START_2K = 12'hC00;
  localparam logic [11:0] BOOT_START_1K = 12'hE00;
  localparam logic [11:0] BOOT_START_05 = 12'hF00;
  localparam logic [11:0] BOOT_START_02 = 12'hF80;
  localparam logic [1:0]  BOOT_SIZE_2K  = 2'h0;
  localparam logic [1:0]  BOOT_SIZE_1K  = 2'h1;
  localparam logic [1:0]  BOOT_SIZE_05  = 2'h2;
endpackage
`default_nettype wire

//--- logic/vtp_vector_table_placement_ctrl.sv
// The implementer's own choices: the register offsets and the Avalon-MM register port.
`timescale 1ns/1ns
`default_nettype none
module vtp_vector_table_placement_ctrl
  import vtp_pkg::*;
(
  input  wire logic                  i_clk,
  input  wire logic                  i_sys_rst,
  input  wire logic [3:0]            i_avs_address,
  input  wire logic                  i_avs_read,
  input  wire logic                  i_avs_write,
  input  wire logic [31:0]           i_avs_writedata,
  output logic      [31:0]           o_avs_readdata,
  output logic                       o_avs_waitrequest,
  input  wire logic                  i_boot_reset_fuse,
  input  wire logic [1:0]            i_boot_size_fuses,
  input  wire logic                  i_app_side_boot_lock,
  input  wire logic                  i_boot_side_boot_lock,
  input  wire logic [vtp_pkg::WADDR_W-1:0] i_exec_pc,
  input  wire logic                  i_instr_retire,
  output logic                       o_irq_block,
  output logic [vtp_pkg::WADDR_W-1:0] o_reset_vector,
  output logic [vtp_pkg::WADDR_W-1:0] o_vector_base,
  output logic                       o_vector_table_select
);
  import vtp_pkg::*;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [11:0] boot_start(input logic [1:0] sz);
    unique case (sz)
      BOOT_SIZE_2K: boot_start = BOOT_START_2K;
      BOOT_SIZE_1K: boot_start = BOOT_START_1K;
      BOOT_SIZE_05: boot_start = BOOT_START_05;
      default:      boot_start = BOOT_START_02;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  logic        ack_r;
  logic        gic_wr;
  logic        sel_wr;
  logic        unl_wr;
  logic        vector_table_select_r;
  logic        vector_change_unlock_r;
  logic [2:0]  unlock_cnt_r;
  logic [1:0]  post_cnt_r;
  logic [11:0] boot_base;
  logic        in_boot;
  logic        block_nxt;

  assign gic_wr = i_avs_write && !ack_r
                  && i_avs_address == GENERAL_INTERRUPT_CONTROL_OFF;
  assign unl_wr = gic_wr && i_avs_writedata[VECTOR_CHANGE_UNLOCK_BIT];
  assign sel_wr = gic_wr && !i_avs_writedata[VECTOR_CHANGE_UNLOCK_BIT]
                  && vector_change_unlock_r;
  assign boot_base = boot_start(i_boot_size_fuses);
  assign in_boot   = i_exec_pc >= boot_base;

  // One wait cycle, answer on second edge
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= (i_avs_read || i_avs_write) && !ack_r;
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_avs_waitrequest <= 1'b1;
    end else begin
      o_avs_waitrequest <= !((i_avs_read || i_avs_write) && !ack_r);
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_avs_readdata <= 32'h0000_0000;
    end else if (i_avs_read && !ack_r) begin
      unique case (i_avs_address)
        GENERAL_INTERRUPT_CONTROL_OFF:
          o_avs_readdata <= {30'h0000_0000, vector_table_select_r,
                             vector_change_unlock_r};
        FUSE_STATUS_OFF:
          o_avs_readdata <= {28'h000_0000, i_boot_side_boot_lock,
                             i_app_side_boot_lock, i_boot_size_fuses[0],
                             i_boot_reset_fuse};
        VECTOR_BASE_OFF:
          o_avs_readdata <= {20'h0_0000, o_reset_vector[11:4],
                             o_vector_base[3:0]};
        default:
          o_avs_readdata <= 32'h0000_0000;
      endcase
    end else begin
      o_avs_readdata <= 32'h0000_0000;
    end
  end

  // ---------------------------------------------------------------
  // Unlock sequence
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      vector_change_unlock_r <= GIC_RESET[VECTOR_CHANGE_UNLOCK_BIT];
      unlock_cnt_r           <= 3'h0;
    end else if (unl_wr) begin
      vector_change_unlock_r <= 1'b1;
      unlock_cnt_r           <= UNLOCK_WINDOW_CNT;
    end else if (sel_wr) begin
      vector_change_unlock_r <= 1'b0;
      unlock_cnt_r           <= 3'h0;
    end else if (unlock_cnt_r != 3'h0) begin
      unlock_cnt_r <= unlock_cnt_r - 3'h1;
      if (unlock_cnt_r == 3'h1) begin
        vector_change_unlock_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      vector_table_select_r <= GIC_RESET[VECTOR_TABLE_SELECT_BIT];
    end else if (sel_wr) begin
      vector_table_select_r <= i_avs_writedata[VECTOR_TABLE_SELECT_BIT];
    end
  end

  // Hold block until the instruction after the select write retires
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      post_cnt_r <= 2'h0;
    end else if (sel_wr) begin
      post_cnt_r <= POST_WRITE_CNT + 2'h1;
    end else if (post_cnt_r != 2'h0 && i_instr_retire) begin
      post_cnt_r <= post_cnt_r - 2'h1;
    end
  end

  // ---------------------------------------------------------------
  // Interrupt blocking and vector placement
  // ---------------------------------------------------------------
  always_comb begin
    block_nxt = unl_wr || (unlock_cnt_r > 3'h1 && !sel_wr)
                || sel_wr || (post_cnt_r != 2'h0
                && !(post_cnt_r == 2'h1 && i_instr_retire));
    if (vector_table_select_r && i_app_side_boot_lock && !in_boot) begin
      block_nxt = 1'b1;
    end
    if (!vector_table_select_r && i_boot_side_boot_lock && in_boot) begin
      block_nxt = 1'b1;
    end
  end

  // Separate gate; global enable flag lives in the core
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_irq_block <= 1'b0;
    end else begin
      o_irq_block <= block_nxt;
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_vector_base         <= APP_START + VECTOR_OFFSET;
      o_reset_vector        <= APP_START;
      o_vector_table_select <= 1'b0;
    end else begin
      o_vector_table_select <= vector_table_select_r;
      o_vector_base <= vector_table_select_r
                       ? boot_base + VECTOR_OFFSET
                       : APP_START + VECTOR_OFFSET;
      o_reset_vector <= i_boot_reset_fuse ? APP_START
                                          : boot_base;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  property p_unlock_timeout;
    @(posedge i_clk) disable iff (i_sys_rst)
    unl_wr ##1 (!gic_wr)[*4] |=> !vector_change_unlock_r;
  endproperty
  a_unlock_timeout: assert property (p_unlock_timeout)
    else $error("unlock bit not cleared after four cycles");

  property p_unlock_set;
    @(posedge i_clk) disable iff (i_sys_rst)
    unl_wr |=> vector_change_unlock_r && o_irq_block;
  endproperty
  a_unlock_set: assert property (p_unlock_set)
    else $error("unlock write did not arm and block");

  property p_sel_clears;
    @(posedge i_clk) disable iff (i_sys_rst)
    sel_wr |=> !vector_change_unlock_r;
  endproperty
  a_sel_clears: assert property (p_sel_clears)
    else $error("unlock bit stayed after select write");

  property p_no_unlock_keep;
    @(posedge i_clk) disable iff (i_sys_rst)
    (gic_wr && !vector_change_unlock_r) |=> $stable(vector_table_select_r);
  endproperty
  a_no_unlock_keep: assert property (p_no_unlock_keep)
    else $error("select changed without unlock");

  property p_block_ends;
    @(posedge i_clk) disable iff (i_sys_rst)
    (unl_wr && !i_app_side_boot_lock && !i_boot_side_boot_lock)
      ##1 (!gic_wr && !i_app_side_boot_lock && !i_boot_side_boot_lock)[*4]
      |=> !o_irq_block;
  endproperty
  a_block_ends: assert property (p_block_ends)
    else $error("blocking did not end after unlock timeout");

  property p_base_sel;
    @(posedge i_clk) disable iff (i_sys_rst)
    vector_table_select_r && i_boot_size_fuses == BOOT_SIZE_2K
      |=> o_vector_base == 12'hC01 || $changed(i_boot_size_fuses);
  endproperty
  a_base_sel: assert property (p_base_sel)
    else $error("boot vector base wrong");

  property p_base_app;
    @(posedge i_clk) disable iff (i_sys_rst)
    !vector_table_select_r |=> o_vector_base == 12'h001 || $rose(
      vector_table_select_r);
  endproperty
  a_base_app: assert property (p_base_app)
    else $error("application vector base wrong");

  property p_reset_vec;
    @(posedge i_clk) disable iff (i_sys_rst)
    i_boot_reset_fuse |=> o_reset_vector == 12'h000
      || $fell(i_boot_reset_fuse);
  endproperty
  a_reset_vec: assert property (p_reset_vec)
    else $error("reset vector not at word zero");

  property p_lock_block;
    @(posedge i_clk) disable iff (i_sys_rst)
    (vector_table_select_r && i_app_side_boot_lock && !in_boot)
      |=> o_irq_block;
  endproperty
  a_lock_block: assert property (p_lock_block)
    else $error("application code not blocked");

  property p_boot_lock_block;
    @(posedge i_clk) disable iff (i_sys_rst)
    (!vector_table_select_r && i_boot_side_boot_lock && in_boot)
      |=> o_irq_block;
  endproperty
  a_boot_lock_block: assert property (p_boot_lock_block)
    else $error("boot loader code not blocked");

  property p_reset_boot;
    @(posedge i_clk) disable iff (i_sys_rst)
    (!i_boot_reset_fuse && i_boot_size_fuses == BOOT_SIZE_2K)
      |=> o_reset_vector == BOOT_START_2K;
  endproperty
  a_reset_boot: assert property (p_reset_boot)
    else $error("reset vector not at boot start");

  property p_base_1k;
    @(posedge i_clk) disable iff (i_sys_rst)
    (vector_table_select_r && i_boot_size_fuses == BOOT_SIZE_1K)
      |=> o_vector_base == BOOT_START_1K + VECTOR_OFFSET;
  endproperty
  a_base_1k: assert property (p_base_1k)
    else $error("boot vector base wrong for smaller section");

  property p_block_held;
    @(posedge i_clk) disable iff (i_sys_rst)
    sel_wr |=> o_irq_block;
  endproperty
  a_block_held: assert property (p_block_held)
    else $error("select write did not hold block");

  property p_reset_state;
    @(posedge i_clk) disable iff (i_sys_rst)
    $fell(i_sys_rst) |-> !vector_table_select_r && !vector_change_unlock_r
      && unlock_cnt_r == 3'h0 && !o_irq_block;
  endproperty
  a_reset_state: assert property (p_reset_state)
    else $error("state not cleared by reset");

endmodule // vtp_vector_table_placement_ctrl
`default_nettype wire

//--- testbench/vtp_core_model.sv
`timescale 1ns/1ns
`default_nettype none
module vtp_core_model (
  input  wire logic        i_clk,
  input  wire logic        i_sys_rst,
  input  wire logic        i_run,
  input  wire logic        i_in_boot,
  output logic      [11:0] o_exec_pc,
  output logic             o_instr_retire
);
  logic [3:0] step_r;
  // ---------------------------------------------------------------
  // Instruction stream
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      step_r <= 4'h0;
      o_instr_retire <= 1'b0;
    end else begin
      step_r <= step_r + {3'h0, i_run};
      o_instr_retire <= i_run;
    end
  end
  // Boot code above the 2K boot base
  assign o_exec_pc = (i_in_boot ? 12'hC10 : 12'h010) + {8'h0, step_r};
endmodule // vtp_core_model
`default_nettype wire

//--- testbench/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
  import vtp_pkg::*;
  logic        i_clk = 1'b0;
  logic        i_sys_rst = 1'b1;
  logic        rd = 1'b0, wr = 1'b0, fuse = 1'b1, alk = 1'b0, blk = 1'b0;
  logic        run = 1'b0, inb = 1'b0;
  logic [1:0]  sz = 2'h0;
  logic [3:0]  adr = 4'h0;
  logic [31:0] wd = 32'h0, rdat, q;
  logic        wreq, blkq, sel, ret;
  logic [11:0] pc, rv, vb;
  logic [11:0] bt [4] = '{BOOT_START_2K, BOOT_START_1K, BOOT_START_05,
                          BOOT_START_02};
  int          n_mismatch = 0, checked = 0, cyc = 0;
  always #50 i_clk = ~i_clk;
  vtp_vector_table_placement_ctrl vtp_vector_table_placement_ctrl_i (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_avs_address(adr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd),
    .o_avs_readdata(rdat), .o_avs_waitrequest(wreq),
    .i_boot_reset_fuse(fuse), .i_boot_size_fuses(sz),
    .i_app_side_boot_lock(alk), .i_boot_side_boot_lock(blk),
    .i_exec_pc(pc), .i_instr_retire(ret), .o_irq_block(blkq),
    .o_reset_vector(rv), .o_vector_base(vb), .o_vector_table_select(sel));
  vtp_core_model vtp_core_model_i (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_run(run), .i_in_boot(inb),
    .o_exec_pc(pc), .o_instr_retire(ret));
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task final_report;
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      final_report;
    end
  end
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge i_clk);
    adr <= a;
    wr <= w;
    rd <= !w;
    wd <= d;
    do begin
      @(posedge i_clk);
    end while (wreq !== 1'b0);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task settle(input int k);
    repeat (k) @(posedge i_clk);
    #1;
  endtask
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task t_reset;
    settle(2);
    bus(1'b0, GENERAL_INTERRUPT_CONTROL_OFF, 32'h0);
    chk("gic", 32'h0, q);
    chk("reset vector", 32'h0, {20'h0, rv});
    chk("vector base", 32'h1, {20'h0, vb});
    chk("block", 32'h0, {31'h0, blkq});
    bus(1'b0, FUSE_STATUS_OFF, 32'h0);
    chk("fuse status", 32'h1, q);
    bus(1'b0, VECTOR_BASE_OFF, 32'h0);
    chk("vector regs", 32'h1, q);
    bus(1'b0, 4'hC, 32'h0);
    chk("unmapped", 32'h0, q);
    $display("test reset done");
  endtask
  task t_locked;
    bus(1'b1, GENERAL_INTERRUPT_CONTROL_OFF, 32'h2);
    bus(1'b0, GENERAL_INTERRUPT_CONTROL_OFF, 32'h0);
    chk("gic", 32'h0, q);
    chk("select", 32'h0, {31'h0, sel});
    $display("test locked done");
  endtask
  task t_region(input logic lock_app);
    @(posedge i_clk);
    alk <= lock_app;
    blk <= !lock_app;
    inb <= !lock_app;
    settle(3);
    chk("block in locked side", 32'h1, {31'h0, blkq});
    bus(1'b0, FUSE_STATUS_OFF, 32'h0);
    chk("fuse status", {28'h0, !lock_app, lock_app, 2'h1}, q);
    @(posedge i_clk);
    inb <= lock_app;
    settle(3);
    chk("block in free side", 32'h0, {31'h0, blkq});
    @(posedge i_clk);
    alk <= 1'b0;
    blk <= 1'b0;
    $display("test region done");
  endtask
  task t_timeout;
    bus(1'b1, GENERAL_INTERRUPT_CONTROL_OFF, 32'h1);
    #1;
    chk("block armed", 32'h1, {31'h0, blkq});
    settle(4);
    chk("block expired", 32'h0, {31'h0, blkq});
    bus(1'b0, GENERAL_INTERRUPT_CONTROL_OFF, 32'h0);
    chk("gic", 32'h0, q);
    bus(1'b1, GENERAL_INTERRUPT_CONTROL_OFF, 32'h2);
    settle(1);
    chk("select after window", 32'h0, {31'h0, sel});
    $display("test timeout done");
  endtask
  task t_move;
    bus(1'b1, GENERAL_INTERRUPT_CONTROL_OFF, 32'h1);
    bus(1'b1, GENERAL_INTERRUPT_CONTROL_OFF, 32'h2);
    #1;
    chk("select", 32'h1, {31'h0, sel});
    chk("block held", 32'h1, {31'h0, blkq});
    chk("vector base", 32'hC01, {20'h0, vb});
    bus(1'b0, GENERAL_INTERRUPT_CONTROL_OFF, 32'h0);
    chk("gic", 32'h2, q);
    @(posedge i_clk);
    run <= 1'b1;
    repeat (2) @(posedge i_clk);
    run <= 1'b0;
    settle(4);
    chk("block released", 32'h0, {31'h0, blkq});
    $display("test move done");
  endtask
  task t_fuses;
    @(posedge i_clk);
    fuse <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      @(posedge i_clk);
      sz <= 2'(i);
      settle(3);
      chk("reset vector", {20'h0, bt[i]}, {20'h0, rv});
      chk("vector base", {20'h0, bt[i] + 12'h1}, {20'h0, vb});
    end
    bus(1'b0, VECTOR_BASE_OFF, 32'h0);
    chk("vector regs", {20'h0, bt[3][11:4], 4'h1}, q);
    @(posedge i_clk);
    fuse <= 1'b1;
    sz <= 2'h0;
    settle(3);
    chk("reset vector", 32'h0, {20'h0, rv});
    $display("test fuses done");
  endtask
  initial begin
    repeat (20) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    t_reset;
    t_locked;
    t_region(1'b0);
    t_timeout;
    t_move;
    t_region(1'b1);
    t_fuses;
    final_report;
  end
endmodule // tb
`default_nettype wire
